// [rtl/render_state_packet_decoder.sv]
// render-state packet decoder with held state and an ahb-lite status view
//
// Overview of operation
// [RULE1] - mask bit set loads field, else hold
// [RULE2] - shade modes bits 10,8,6,4; 1 flat
// [RULE3] - cull field 2:0; reserved codes ignored
// [RULE4] - client 3, type 03h/04h boolean packets
// [RULE5] - boolean one enables at even bits 0-10
// [RULE6] - specular setup tied to specular enable
// [RULE7] - alpha setup enable at bit 16
// [RULE8] - chroma key bit 12, index key 14
// [RULE9] - sender flushes after mapping cache change
// [RULE10] - dither enables bits 14,12,10,8 packet two
// [RULE11] - frame and depth write enables gate writes
// [RULE12] - fog color red, green, blue fields
// [RULE13] - fog color is type 15h non-pipelined
// [RULE14] - drawing rect 1Dh, opcode 80h, four words
// [RULE15] - payload bit 31 clear enables clipping
// [RULE16] - x and y dither bias fields
// [RULE17] - clipped corners: 10-bit y, 11-bit x
// [RULE18] - signed origin y 26:16, x 11:0
// [RULE19] - sender clips rectangle to screen
// [RULE20] - sender keeps rectangle over one pixel
// [RULE21] - scissor packet 1Ch opcode 10h, id 0
// [RULE22] - only inclusive scissoring exists
// [RULE23] - scissor enable bit 0, mask bit 1
// [RULE24] - reserved encodings ignored, state held
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "render_state_map.svh"
module render_state_packet_decoder (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // instruction word stream
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_word,
  output logic cmd_ready,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // held state toward the pipeline
  output logic [3:0] shade_flat,
  output logic [2:0] cull_mode,
  output logic [19:0] bool_one,
  output logic [16:0] bool_two,
  output logic [15:0] fog_color,
  output render_state_pkg::draw_rect_type draw_rect,
  output logic scissor_enable,
  output logic color_write_gate,
  output logic depth_write_gate,
  output logic packet_error
);
  import render_state_pkg::*;

  logic [3:0] shade_q, shade_d;
  logic [2:0] cull_q, cull_d;
  logic [19:0] b1_q, b1_d;
  logic [16:0] b2_q, b2_d;
  logic [15:0] fog_q;
  draw_rect_type rect_q, rect_d;
  logic scissor_q;
  logic err_q;
  logic stream_off_q;
  dec_state_type state_q;
  logic [1:0] word_q;
  logic [31:0] rdata_q;
  logic [31:0] addr_q;
  logic rd_pend_q, wr_pend_q;

  wire go = clk_en & cmd_valid;
  wire [2:0] client = cmd_word[31:29];
  wire [4:0] stype = cmd_word[28:24];
  wire is_render = (client == `RS_CLIENT_RENDER); // [RULE4]
  wire hdr = go & (state_q == dec_idle) & is_render & ~stream_off_q;
  wire is_shade = hdr & (stype == `RS_TYPE_CULL_SHADE);
  wire is_b1 = hdr & (stype == `RS_TYPE_BOOL_ONE); // [RULE4]
  wire is_b2 = hdr & (stype == `RS_TYPE_BOOL_TWO); // [RULE4]
  wire is_fog = hdr & (stype == `RS_TYPE_FOG_COLOR); // [RULE13]
  wire is_rect = hdr & (stype == `RS_TYPE_MULTIWORD_NP)
    & (cmd_word[23:16] == `RS_OPC_DRAW_RECT)
    & (cmd_word[15:0] == `RS_LEN_DRAW_RECT); // [RULE14]
  // a second rectangle id does not exist, so such a packet is dropped
  wire is_scis = hdr & (stype == `RS_TYPE_NARROW_NP)
    & (cmd_word[23:19] == `RS_OPC_SCISSOR_EN)
    & ~cmd_word[`RS_BIT_SCISSOR_ID]; // [RULE21] [RULE22]
  wire hdr_bad = hdr & ~(is_shade | is_b1 | is_b2 | is_fog | is_rect | is_scis);
  wire cull_ok = (cmd_word[2:0] >= `RS_CULL_NONE)
    & (cmd_word[2:0] <= `RS_CULL_BOTH); // [RULE3] [RULE24]
  wire rect_word = go & (state_q == dec_rect);

  assign cmd_ready = clk_en;

  // per-field masked update of both boolean packets and the shade modes
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : gen_b1
      if (g == 9) begin : gen_tied
        // setup specular has no state of its own, so it follows the main enable
        assign b1_d[2*g] = b1_d[`RS_BIT_SPEC_EN]; // [RULE6]
      end else begin : gen_live
        assign b1_d[2*g] = (is_b1 & cmd_word[2*g+1]) ? cmd_word[2*g] : b1_q[2*g]; // [RULE1] [RULE5]
      end
      assign b1_d[2*g+1] = 1'b0;
    end
    for (g = 0; g < 9; g = g + 1) begin : gen_b2
      if (g == 2 || g == 3) begin : gen_rsvd
        // bits 7:4 of packet two are reserved; a sender setting them changes nothing
        assign b2_d[2*g] = 1'b0; // [RULE24]
      end else begin : gen_live
        assign b2_d[2*g] = (is_b2 & cmd_word[2*g+1]) ? cmd_word[2*g] : b2_q[2*g]; // [RULE1] [RULE10]
      end
      if (2*g+1 < 17) begin : gen_odd
        assign b2_d[2*g+1] = 1'b0;
      end
    end
    for (g = 0; g < 4; g = g + 1) begin : gen_shade
      assign shade_d[g] = (is_shade & cmd_word[2*g+5]) ? cmd_word[2*g+4] : shade_q[g]; // [RULE2]
    end
  endgenerate

  assign cull_d = (is_shade & cmd_word[3] & cull_ok) ? cmd_word[2:0] : cull_q; // [RULE3]

  always_comb begin
    rect_d = rect_q;
    if (rect_word) begin
      case (word_q)
        2'd0: begin
          rect_d.clip_disable = cmd_word[`RS_BIT_CLIP_DISABLE]; // [RULE15]
          rect_d.x_bias = cmd_word[27:26]; // [RULE16]
          rect_d.y_bias = cmd_word[25:24]; // [RULE16]
        end
        2'd1: begin
          rect_d.ymin = cmd_word[25:16]; // [RULE17]
          rect_d.xmin = cmd_word[10:0]; // [RULE17]
        end
        2'd2: begin
          rect_d.ymax = cmd_word[25:16]; // [RULE17]
          rect_d.xmax = cmd_word[10:0]; // [RULE17]
        end
        default: begin
          rect_d.origin_y = cmd_word[26:16]; // [RULE18]
          rect_d.origin_x = cmd_word[11:0]; // [RULE18]
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      shade_q <= 4'h0;
      cull_q <= `RS_CULL_RESET;
      b1_q <= 20'h0_0000;
      b2_q <= 17'h0_0000;
      fog_q <= 16'h0000;
      rect_q <= '0;
      scissor_q <= 1'b0;
    end else if (clk_en) begin
      shade_q <= shade_d;
      cull_q <= cull_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      rect_q <= rect_d;
      if (is_fog)
        fog_q <= {cmd_word[23:19], cmd_word[15:10], cmd_word[7:3]}; // [RULE12] [RULE13]
      if (is_scis & cmd_word[1])
        scissor_q <= cmd_word[0]; // [RULE23] [RULE1]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= dec_idle;
      word_q <= 2'd0;
    end else if (clk_en) begin
      case (state_q)
        dec_idle: begin
          word_q <= 2'd0;
          if (is_rect)
            state_q <= dec_rect; // [RULE14]
        end
        dec_rect: begin
          if (cmd_valid) begin
            word_q <= word_q + 2'd1;
            if (word_q == 2'd3)
              state_q <= dec_idle;
          end
        end
        default: state_q <= dec_idle;
      endcase
    end
  end

  // sticky flag for dropped headers; a new drop wins over a software clear
  wire err_clear = wr_pend_q & clk_en & (addr_q == `RS_ADDR_STATUS) & hwdata[0];
  always_ff @(posedge clk_sys) begin
    if (!resetn)
      err_q <= 1'b0;
    else if (clk_en & hdr_bad)
      err_q <= 1'b1; // [RULE24]
    else if (err_clear)
      err_q <= 1'b0;
  end

  // ahb-lite slave: zero wait states, always okay
  wire take = clk_en & hsel & hready & htrans[1];
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_q <= 32'h0000_0000;
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (clk_en) begin
      rd_pend_q <= take & ~hwrite;
      wr_pend_q <= take & hwrite;
      if (take)
        addr_q <= {haddr[31:2], 2'b00};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn)
      stream_off_q <= 1'b0;
    else if (wr_pend_q & clk_en & (addr_q == `RS_ADDR_CONTROL))
      stream_off_q <= hwdata[0];
  end

  wire [31:0] rd_mux =
    (haddr[31:2] == `RS_ADDR_STATUS >> 2) ? {29'h0, stream_off_q, state_q == dec_rect, err_q} :
    (haddr[31:2] == `RS_ADDR_BOOL_ONE >> 2) ? {12'h000, b1_q} :
    (haddr[31:2] == `RS_ADDR_BOOL_TWO >> 2) ? {15'h0000, b2_q} :
    (haddr[31:2] == `RS_ADDR_SHADE >> 2) ? {24'h00_0000, scissor_q, shade_q, cull_q} :
    (haddr[31:2] == `RS_ADDR_FOG >> 2) ? {16'h0000, fog_q} :
    (haddr[31:2] == `RS_ADDR_CLIP_MIN >> 2) ? {6'h00, rect_q.ymin, 5'h00, rect_q.xmin} :
    (haddr[31:2] == `RS_ADDR_CLIP_MAX >> 2) ? {6'h00, rect_q.ymax, 5'h00, rect_q.xmax} :
    (haddr[31:2] == `RS_ADDR_ORIGIN >> 2) ? {5'h00, rect_q.origin_y, 4'h0, rect_q.origin_x} :
    (haddr[31:2] == `RS_ADDR_CONTROL >> 2) ?
      {rect_q.clip_disable, 3'h0, rect_q.x_bias, rect_q.y_bias, 23'h0, stream_off_q} :
    32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!resetn)
      rdata_q <= 32'h0000_0000;
    else if (take & ~hwrite)
      rdata_q <= rd_mux;
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign shade_flat = shade_q;
  assign cull_mode = cull_q;
  // setup specular mirrors the main specular enable
  assign bool_one = b1_q; // [RULE6]
  assign bool_two = b2_q;
  assign fog_color = fog_q;
  assign draw_rect = rect_q;
  assign scissor_enable = scissor_q;
  // buffer writes are gated by held enables; mapping cache flush is the sender's job
  assign color_write_gate = b2_q[`RS_BIT_FBUF_WR]; // [RULE11] [RULE9]
  assign depth_write_gate = b2_q[`RS_BIT_ZBUF_WR]; // [RULE11]
  assign packet_error = err_q;

  property p_masked(logic hit, logic m, logic v, logic q);
    @(posedge clk_sys) disable iff (!resetn)
      (clk_en & hit & m) |=> (q == $past(v));
  endproperty
  sequence s_rect_hdr;
    clk_en & is_rect;
  endsequence

  a_z_enable_load: assert property (p_masked(is_b1, cmd_word[1], cmd_word[0], b1_q[0]))
    else $error("z enable not loaded"); // [RULE5]
  a_alpha_setup_load: assert property (p_masked(is_b1, cmd_word[17], cmd_word[16], b1_q[16]))
    else $error("alpha setup not loaded"); // [RULE7]
  a_chroma_key_load: assert property (p_masked(is_b1, cmd_word[13], cmd_word[12], b1_q[12]))
    else $error("chroma key not loaded"); // [RULE8]
  a_dither_load: assert property (p_masked(is_b2, cmd_word[13], cmd_word[12], b2_q[12]))
    else $error("fog dither not loaded"); // [RULE10]
  a_alpha_shade_load: assert property (p_masked(is_shade, cmd_word[11], cmd_word[10],
    shade_q[3])) else $error("alpha shade not loaded"); // [RULE2]
  a_masked_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en & is_b1 & ~cmd_word[9]) |=> $stable(b1_q[8]))
    else $error("specular changed without mask"); // [RULE1]
  a_cull_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en & is_shade & cmd_word[3] & ~cull_ok) |=> $stable(cull_q))
    else $error("reserved cull code loaded"); // [RULE3]
  a_spec_tied: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en & is_b1 & cmd_word[9]) |=> (bool_one[18] == $past(cmd_word[8])))
    else $error("specular setup not tied"); // [RULE6]
  a_rect_walk: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_rect_hdr |=> (state_q == dec_rect) && (word_q == 2'd0))
    else $error("rectangle packet not entered"); // [RULE14]
  a_fog_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en & is_fog) |=> fog_q[15:11] == $past(cmd_word[23:19]))
    else $error("fog red not loaded"); // [RULE12]
  a_scissor_id: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en & hdr & cmd_word[16] & (stype == `RS_TYPE_NARROW_NP)) |=> $stable(scissor_q))
    else $error("scissor id one accepted"); // [RULE21]
  a_write_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en & is_b2 & cmd_word[3]) |=> (color_write_gate == $past(cmd_word[2])))
    else $error("frame write gate wrong"); // [RULE11]
endmodule

// [rtl/render_state_map.svh]
// offsets, field positions, codes and reset values of the render-state decoder
`ifndef RENDER_STATE_MAP_SVH
`define RENDER_STATE_MAP_SVH
`define RS_CLIENT_RENDER 3'h3
`define RS_TYPE_CULL_SHADE 5'h02
`define RS_TYPE_BOOL_ONE 5'h03
`define RS_TYPE_BOOL_TWO 5'h04
`define RS_TYPE_FOG_COLOR 5'h15
`define RS_TYPE_NARROW_NP 5'h1c
`define RS_TYPE_MULTIWORD_NP 5'h1d
`define RS_OPC_DRAW_RECT 8'h80
`define RS_OPC_SCISSOR_EN 5'h10
`define RS_LEN_DRAW_RECT 16'h0003
`define RS_CULL_NONE 3'h1
`define RS_CULL_BOTH 3'h4
`define RS_CULL_RESET 3'h1
`define RS_BIT_ALPHA_SHADE 10
`define RS_BIT_FOG_SHADE 8
`define RS_BIT_SPEC_SHADE 6
`define RS_BIT_COLOR_SHADE 4
`define RS_BIT_Z_EN 0
`define RS_BIT_BLEND_EN 2
`define RS_BIT_ALPHA_TEST 4
`define RS_BIT_FOG_EN 6
`define RS_BIT_SPEC_EN 8
`define RS_BIT_ZBIAS_EN 10
`define RS_BIT_CHROMA_KEY 12
`define RS_BIT_INDEX_KEY 14
`define RS_BIT_ALPHA_SETUP 16
`define RS_BIT_SPEC_SETUP 18
`define RS_BIT_ZBUF_WR 0
`define RS_BIT_FBUF_WR 2
`define RS_BIT_COLOR_DITHER 8
`define RS_BIT_SPEC_DITHER 10
`define RS_BIT_FOG_DITHER 12
`define RS_BIT_ALPHA_DITHER 14
`define RS_BIT_MAP_CACHE 16
`define RS_BIT_SCISSOR_ID 16
`define RS_BIT_CLIP_DISABLE 31
`define RS_ADDR_STATUS 32'h0000_0000
`define RS_ADDR_BOOL_ONE 32'h0000_0004
`define RS_ADDR_BOOL_TWO 32'h0000_0008
`define RS_ADDR_SHADE 32'h0000_000c
`define RS_ADDR_FOG 32'h0000_0010
`define RS_ADDR_CLIP_MIN 32'h0000_0014
`define RS_ADDR_CLIP_MAX 32'h0000_0018
`define RS_ADDR_ORIGIN 32'h0000_001c
`define RS_ADDR_CONTROL 32'h0000_0020
`endif

// [rtl/render_state_pkg.sv]
// types shared by the render-state decoder
package render_state_pkg;
  typedef struct packed {
    logic htrans_nonseq;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } ahb_req_type;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_type;
  typedef struct packed {
    logic clip_disable;
    logic [1:0] x_bias;
    logic [1:0] y_bias;
    logic [9:0] ymin;
    logic [10:0] xmin;
    logic [9:0] ymax;
    logic [10:0] xmax;
    logic [10:0] origin_y;
    logic [11:0] origin_x;
  } draw_rect_type;
  typedef enum logic [1:0] {dec_idle, dec_rect} dec_state_type;
endpackage

// [verification/cmd_source_model.sv]
// instruction parser model driving the decoder's word stream
`timescale 1ns/1ns
module cmd_source_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // word stream
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [31:0] cmd_word
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 32'h0000_0000;
  end
  // idle line shows the inverted word, so a stale value never passes for data
  task automatic send(input logic [31:0] w, input int gap);
    if (gap > 0) begin
      cmd_valid <= 1'b0;
      cmd_word <= ~cmd_word;
      repeat (gap) @(posedge clk_sys);
    end
    cmd_valid <= 1'b1;
    cmd_word <= w;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
  endtask
  task automatic quiet();
    cmd_valid <= 1'b0;
    cmd_word <= ~cmd_word;
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the render-state packet decoder
`timescale 1ns/1ns
`include "render_state_map.svh"
module tb_top;
  import render_state_pkg::*;
  logic clk_sys, resetn, clk_en, stall_on, cmd_valid, cmd_ready, hsel, hwrite, hreadyout, hresp;
  logic [31:0] cmd_word, haddr, hwdata, hrdata, seed, en_seed, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, cull_mode, e_cull;
  logic [3:0] shade_flat, e_shade;
  logic [19:0] bool_one, e_one;
  logic [16:0] bool_two, e_two;
  logic [15:0] fog_color, e_fog;
  draw_rect_type draw_rect, e_rect;
  logic scissor_enable, color_write_gate, depth_write_gate, packet_error, e_sc;
  int err_count, tests_run, cycles, rect_n;
  logic [31:0] pkt[$];
  render_state_packet_decoder uut (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_ready(cmd_ready), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .shade_flat(shade_flat), .cull_mode(cull_mode), .bool_one(bool_one),
    .bool_two(bool_two), .fog_color(fog_color), .draw_rect(draw_rect),
    .scissor_enable(scissor_enable), .color_write_gate(color_write_gate),
    .depth_write_gate(depth_write_gate), .packet_error(packet_error));
  cmd_source_model src (.clk_sys(clk_sys), .resetn(resetn), .cmd_ready(cmd_ready),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] rnd();
    seed = lfsr(seed);
    return seed;
  endfunction
  // random stalls come from a separate register so the word stream stays reproducible
  always @(posedge clk_sys) begin
    en_seed <= lfsr(en_seed);
    clk_en <= stall_on ? (en_seed[2:0] != 3'h0) : 1'b1;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [79:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s mismatch", $time, what);
    end
  endtask
  task automatic apply(input logic [31:0] w);
    if (rect_n > 0) begin
      case (rect_n)
        4: {e_rect.clip_disable, e_rect.x_bias, e_rect.y_bias} = {w[31], w[27:24]};
        3: {e_rect.ymin, e_rect.xmin} = {w[25:16], w[10:0]};
        2: {e_rect.ymax, e_rect.xmax} = {w[25:16], w[10:0]};
        default: {e_rect.origin_y, e_rect.origin_x} = {w[26:16], w[11:0]};
      endcase
      rect_n--;
    end else if (w[31:29] == `RS_CLIENT_RENDER) begin
      case (w[28:24])
        `RS_TYPE_CULL_SHADE: begin
          for (int i = 0; i < 4; i++) if (w[11 - 2 * i]) e_shade[3 - i] = w[10 - 2 * i];
          if (w[3] && w[2:0] inside {[3'h1:3'h4]}) e_cull = w[2:0];
        end
        `RS_TYPE_BOOL_ONE: begin
          for (int i = 0; i < 20; i += 2) if (w[i + 1]) e_one[i] = w[i];
          e_one[18] = e_one[8];
        end
        `RS_TYPE_BOOL_TWO: for (int i = 0; i < 17; i += 2)
          if (w[i + 1] && i != 4 && i != 6) e_two[i] = w[i];
        `RS_TYPE_FOG_COLOR: e_fog = {w[23:19], w[15:10], w[7:3]};
        `RS_TYPE_NARROW_NP: if (w[23:19] == `RS_OPC_SCISSOR_EN && !w[16] && w[1]) e_sc = w[0];
        `RS_TYPE_MULTIWORD_NP: rect_n = 4;
        default: ;
      endcase
    end
  endtask
  task automatic check_state();
    cmp({shade_flat, cull_mode, scissor_enable}, {e_shade, e_cull, e_sc}, "mode");
    cmp(bool_one, e_one, "bool one");
    cmp(bool_two, e_two, "bool two");
    cmp({color_write_gate, depth_write_gate}, {e_two[2], e_two[0]}, "wr");
    cmp(fog_color, e_fog, "fog");
    cmp(draw_rect, e_rect, "rect");
  endtask
  task automatic run_pkt(input int k);
    logic [31:0] r;
    pkt.delete();
    r = rnd();
    case (k)
      0: pkt.push_back({3'h3, `RS_TYPE_CULL_SHADE, r[23:0]});
      1: pkt.push_back({3'h3, `RS_TYPE_BOOL_ONE, 4'h0, r[19:0]});
      2: pkt.push_back({3'h3, `RS_TYPE_BOOL_TWO, 6'h00, r[17:0]});
      3: pkt.push_back({3'h3, `RS_TYPE_FOG_COLOR, r[23:0]});
      4: pkt.push_back({3'h3, `RS_TYPE_NARROW_NP, `RS_OPC_SCISSOR_EN, 3'h0, 14'h0000, r[1:0]});
      5: begin
        pkt.push_back({3'h3, `RS_TYPE_MULTIWORD_NP, `RS_OPC_DRAW_RECT, `RS_LEN_DRAW_RECT});
        pkt.push_back(rnd());
        r = rnd();
        pkt.push_back({7'h00, r[24:16], 6'h00, r[9:0]});
        pkt.push_back({7'h01, r[24:16], 6'h01, r[9:0]});
        pkt.push_back(rnd());
      end
      default: pkt.push_back({3'h3, `RS_TYPE_NARROW_NP, `RS_OPC_SCISSOR_EN, 3'h1, 15'h0001, ~e_sc});
    endcase
    // a flush word of another client follows any mapping cache update
    if (k == 2 && r[17]) pkt.push_back(32'h0000_0000);
    foreach (pkt[i]) begin
      apply(pkt[i]);
      src.send(pkt[i], (r[31:30] == 2'h3) ? 2 : 0);
    end
    src.quiet();
    @(posedge clk_sys);
    check_state();
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmp(hresp, 1'b0, "bus response");
  endtask
  initial begin
    seed = 32'h91bb5460;
    en_seed = 32'h91bb5460;
    {resetn, stall_on, hsel, hwrite, htrans, haddr, hwdata} = '0;
    clk_en = 1'b1;
    hsize = 3'h2;
    {err_count, tests_run, cycles, rect_n} = '0;
    {e_shade, e_one, e_two, e_fog, e_rect, e_sc} = '0;
    e_cull = `RS_CULL_RESET;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check_state();
    stall_on = 1'b1;
    for (int i = 0; i < 360; i++) run_pkt(i % 6);
    stall_on = 1'b0;
    repeat (2) @(posedge clk_sys);
    ahb(1'b0, `RS_ADDR_BOOL_ONE, 32'h0);
    cmp(rd, {12'h000, e_one}, "bus bool one");
    ahb(1'b0, `RS_ADDR_SHADE, 32'h0);
    cmp(rd, {24'h0, e_sc, e_shade, e_cull}, "bus shade");
    ahb(1'b0, 32'h0000_0040, 32'h0);
    cmp(rd, 32'h0, "bus unmapped");
    run_pkt(6);
    cmp(packet_error, 1'b1, "error flag");
    ahb(1'b0, `RS_ADDR_STATUS, 32'h0);
    cmp(rd[2:0], 3'h1, "status");
    ahb(1'b1, `RS_ADDR_STATUS, 32'h1);
    ahb(1'b0, `RS_ADDR_STATUS, 32'h0);
    cmp({rd[0], packet_error}, 2'h0, "error clear");
    // stream switched off: a full-mask packet must leave all held state alone
    ahb(1'b1, `RS_ADDR_CONTROL, 32'h1);
    src.send({3'h3, `RS_TYPE_BOOL_ONE, 24'h0f_ffff}, 0);
    src.quiet();
    @(posedge clk_sys);
    check_state();
    ahb(1'b0, `RS_ADDR_CONTROL, 32'h0);
    cmp(rd, {e_rect.clip_disable, 3'h0, e_rect.x_bias, e_rect.y_bias, 23'h0, 1'b1}, "control");
    ahb(1'b1, `RS_ADDR_CONTROL, 32'h0);
    print_verdict();
  end
endmodule
